/* tlb_ctrl_pkg.sv */
package tlb_ctrl_pkg;
  // control register selects on the pipeline's control-register port
  localparam logic [1:0] SEL_PAGE_TABLE_POINTER = 2'h0;
  localparam logic [1:0] SEL_TLB_ENTRY_ACCESS = 2'h1;
  localparam logic [1:0] SEL_TLB_MISC_CONTROL = 2'h2;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // page_table_pointer fields
  localparam int PTP_VPN_LSB = 2;
  localparam int PTP_VPN_W = 20;
  localparam int PTP_BASE_LSB = 22;
  localparam int PTP_BASE_W = 10;
  // tlb_entry_access fields
  localparam int ACC_PFN_LSB = 0;
  localparam int ACC_PFN_W = 20;
  localparam int ACC_GLOBAL_BIT = 20;
  localparam int ACC_EXEC_BIT = 21;
  localparam int ACC_WRITE_BIT = 22;
  localparam int ACC_READ_BIT = 23;
  localparam int ACC_CACHE_BIT = 24;
  localparam int ACC_STORED_W = 25;
  // tlb_misc_control fields
  localparam int MISC_DATA_BIT = 0;
  localparam int MISC_ACCESS_VIOLATION_FLAG_BIT = 1;
  localparam int MISC_BAD_BIT = 2;
  localparam int MISC_DBL_BIT = 3;
  localparam int MISC_PID_LSB = 4;
  localparam int MISC_WE_BIT = 18;
  localparam int MISC_RD_BIT = 19;
  localparam int MISC_SET_LSB = 20;
  localparam int MISC_EE_BIT = 24;
  localparam int PID_W_MAX = 14;
  localparam int SET_W_MAX = 4;
  localparam int MAX_SETS = 16;
  localparam int TLB_READ_CYCLES = 1;
endpackage

/* tlb_entry_store.sv */
`timescale 1ns/1ps
module tlb_entry_store
  import tlb_ctrl_pkg::*;
#(
  parameter int LINE_W = 4,
  parameter int SET_W = 2,
  parameter int DATA_W = 40
)
(
  input wire logic sys_clk_in,
  input wire logic clk_en_in,
  input wire logic wr_en_in,
  input wire logic [LINE_W-1:0] wr_line_in,
  input wire logic [SET_W-1:0] wr_set_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic [LINE_W-1:0] rd_line_in,
  input wire logic [SET_W-1:0] rd_set_in,
  output logic [DATA_W-1:0] rd_data_out,
  input wire logic [LINE_W-1:0] look_line_in,
  output logic [DATA_W-1:0] look_data_out
);
  logic [DATA_W-1:0] mem_q [(2**(LINE_W+SET_W))-1:0];

  // no reset on the array: contents are undefined until software fills them
  always_ff @(posedge sys_clk_in)
  begin
    if (clk_en_in && wr_en_in)
    begin
      mem_q[{wr_set_in, wr_line_in}] <= wr_data_in;
    end
  end

  assign rd_data_out = mem_q[{rd_set_in, rd_line_in}];
  // lookup port sees set 0 only; other sets are reached by software reads
  assign look_data_out = mem_q[{{SET_W{1'b0}}, look_line_in}];
endmodule // tlb_entry_store

/* tlb_access_control.sv */
`timescale 1ns/1ps
module tlb_access_control
  import tlb_ctrl_pkg::*;
#(
  parameter int PID_W = 8,
  parameter int NUM_SETS = 4,
  parameter int LINE_W = 4,
  parameter bit MMU_PRESENT = 1'b1
)
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic ctl_wr_in,
  input wire logic ctl_rd_in,
  input wire logic [1:0] ctl_sel_in,
  input wire logic [31:0] ctl_wdata_in,
  output logic [31:0] ctl_rdata_out,
  output logic ctl_busy_out,
  input wire logic exc_take_in,
  input wire logic exc_handling_bit_in,
  input wire logic exc_fast_miss_in,
  input wire logic exc_double_miss_in,
  input wire logic exc_access_violation_flag_in,
  input wire logic exc_bad_addr_in,
  input wire logic exc_data_in,
  input wire logic [PTP_VPN_W-1:0] exc_vpn_in,
  input wire logic ecc_enable_in,
  input wire logic ecc_error_in,
  input wire logic [PTP_VPN_W-1:0] lookup_vpn_in,
  input wire logic lookup_is_load_in,
  input wire logic lookup_is_store_in,
  input wire logic lookup_is_fetch_in,
  output logic lookup_hit_out,
  output logic lookup_allowed_out,
  output logic lookup_cacheable_out,
  output logic [ACC_PFN_W-1:0] lookup_pfn_out
);
  localparam int SET_W = (NUM_SETS > 1) ? $clog2(NUM_SETS) : 1;
  localparam int TAG_W = PTP_VPN_W - LINE_W;
  localparam int DATA_W = ACC_STORED_W + TAG_W + PID_W;

  // rule checks on build parameters
  if (NUM_SETS > MAX_SETS || NUM_SETS < 1)
  begin : g_bad_sets
    $error("set count out of range");
  end
  if (PID_W < 8 || PID_W > PID_W_MAX)
  begin : g_bad_pid
    $error("process identifier width out of range");
  end

  typedef enum logic [0:0] {IDLE, READ_LOAD} rd_state_e;

  logic [PTP_BASE_W-1:0] page_table_base_q;
  logic [PTP_VPN_W-1:0] virtual_page_number_q;
  logic [ACC_STORED_W-1:0] entry_access_q;
  logic [PID_W-1:0] process_identifier_q;
  logic [SET_W-1:0] set_select_q;
  logic write_enable_q;
  logic soft_ecc_error_flag_q;
  logic double_miss_flag_q;
  logic bad_addr_flag_q;
  logic access_violation_flag_q;
  logic data_access_flag_q;
  rd_state_e rd_state_q;

  logic wr_ptp, wr_acc, wr_misc, rd_trigger, tlb_write, read_load, exc_vpn_load;
  logic [DATA_W-1:0] store_wdata, store_rdata, lookup_rdata;
  logic [31:0] misc_view;
  logic [SET_W-1:0] set_wval;

  assign wr_ptp = MMU_PRESENT && ctl_wr_in && ctl_sel_in == SEL_PAGE_TABLE_POINTER;
  assign wr_acc = MMU_PRESENT && ctl_wr_in && ctl_sel_in == SEL_TLB_ENTRY_ACCESS;
  assign wr_misc = MMU_PRESENT && ctl_wr_in && ctl_sel_in == SEL_TLB_MISC_CONTROL;
  assign rd_trigger = wr_misc && ctl_wdata_in[MISC_RD_BIT];
  assign tlb_write = wr_acc && write_enable_q;
  assign read_load = rd_state_q == READ_LOAD;
  assign exc_vpn_load = exc_take_in && !exc_handling_bit_in
    && (exc_fast_miss_in || exc_access_violation_flag_in);
  assign set_wval = ctl_wdata_in[MISC_SET_LSB +: SET_W];
  // stall reads while the entry is being fetched
  assign ctl_busy_out = read_load;

  // read sequencer: trigger cycle, then one load cycle
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rd_state_q <= IDLE;
    else if (clk_en_in)
    begin
      case (rd_state_q)
        IDLE: if (rd_trigger) rd_state_q <= READ_LOAD;
        // a trigger in the load cycle queues another load
        READ_LOAD: rd_state_q <= rd_trigger ? READ_LOAD : IDLE;
        default: rd_state_q <= IDLE;
      endcase
    end
  end

  // page table base: software only
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      page_table_base_q <= REG_RESET[PTP_BASE_W-1:0];
    else if (clk_en_in && wr_ptp)
      page_table_base_q <= ctl_wdata_in[PTP_BASE_LSB +: PTP_BASE_W];
  end

  // vpn: read data wins over exception, exception over software
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      virtual_page_number_q <= REG_RESET[PTP_VPN_W-1:0];
    else if (clk_en_in)
    begin
      if (read_load)
        virtual_page_number_q[PTP_VPN_W-1 -: TAG_W] <= store_rdata[PID_W +: TAG_W];
      else if (exc_vpn_load)
        virtual_page_number_q <= exc_vpn_in;
      else if (wr_ptp)
        virtual_page_number_q <= ctl_wdata_in[PTP_VPN_LSB +: PTP_VPN_W];
    end
  end

  // entry access: os reserved bits never stored
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      entry_access_q <= REG_RESET[ACC_STORED_W-1:0];
    else if (clk_en_in)
    begin
      if (read_load)
        entry_access_q <= store_rdata[DATA_W-1 -: ACC_STORED_W];
      else if (wr_acc)
        entry_access_q <= ctl_wdata_in[ACC_STORED_W-1:0];
    end
  end

  // pid: value read from the entry has priority over the software write
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      process_identifier_q <= REG_RESET[PID_W-1:0];
    else if (clk_en_in)
    begin
      if (read_load)
        process_identifier_q <= store_rdata[PID_W-1:0];
      else if (wr_misc)
        process_identifier_q <= ctl_wdata_in[MISC_PID_LSB +: PID_W];
    end
  end

  // set select wraps at the configured set count
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      set_select_q <= REG_RESET[SET_W-1:0];
    else if (clk_en_in)
    begin
      if (tlb_write)
        set_select_q <= (set_select_q == SET_W'(NUM_SETS - 1)) ? '0
          : set_select_q + 1'b1;
      else if (wr_misc)
        set_select_q <= set_wval;
    end
  end

  // write enable: hardware set wins over software write
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      write_enable_q <= 1'b0;
    else if (clk_en_in)
    begin
      if (exc_take_in && (exc_access_violation_flag_in
          || ((exc_fast_miss_in || exc_double_miss_in) && !exc_handling_bit_in)))
        write_enable_q <= 1'b1;
      else if (wr_misc)
        write_enable_q <= ctl_wdata_in[MISC_WE_BIT];
    end
  end

  // ecc flag: hardware set wins over the software write
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      soft_ecc_error_flag_q <= 1'b0;
    else if (clk_en_in)
    begin
      if (read_load && ecc_enable_in && ecc_error_in)
        soft_ecc_error_flag_q <= 1'b1;
      else if (wr_misc)
        soft_ecc_error_flag_q <= ctl_wdata_in[MISC_EE_BIT] & ecc_enable_in;
    end
  end

  // exception flags refreshed on every general exception
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      double_miss_flag_q <= 1'b0;
      bad_addr_flag_q <= 1'b0;
      access_violation_flag_q <= 1'b0;
      data_access_flag_q <= 1'b0;
    end
    else if (clk_en_in && exc_take_in)
    begin
      double_miss_flag_q <= exc_double_miss_in;
      bad_addr_flag_q <= exc_bad_addr_in;
      access_violation_flag_q <= exc_access_violation_flag_in;
      data_access_flag_q <= exc_data_in;
    end
  end

  // write uses the incoming access value, not the stale register
  assign store_wdata = {ctl_wdata_in[ACC_STORED_W-1:0],
    virtual_page_number_q[PTP_VPN_W-1 -: TAG_W], process_identifier_q};
  tlb_entry_store #(
    .LINE_W(LINE_W),
    .SET_W(SET_W),
    .DATA_W(DATA_W)
  ) u_store (
    .sys_clk_in(sys_clk_in),
    .clk_en_in(clk_en_in),
    .wr_en_in(tlb_write),
    .wr_line_in(virtual_page_number_q[LINE_W-1:0]),
    .wr_set_in(set_select_q),
    .wr_data_in(store_wdata),
    .rd_line_in(virtual_page_number_q[LINE_W-1:0]),
    .rd_set_in(set_select_q),
    .rd_data_out(store_rdata),
    .look_line_in(lookup_vpn_in[LINE_W-1:0]),
    .look_data_out(lookup_rdata)
  );

  // lookup view of the entry in set 0 for the presented page
  always_comb
  begin
    lookup_hit_out = (lookup_rdata[PID_W +: TAG_W] == lookup_vpn_in[PTP_VPN_W-1 -: TAG_W])
      && (lookup_rdata[PID_W + TAG_W + ACC_GLOBAL_BIT]
      || lookup_rdata[PID_W-1:0] == process_identifier_q);
    lookup_allowed_out = lookup_hit_out
      && !(lookup_is_load_in && !lookup_rdata[PID_W + TAG_W + ACC_READ_BIT])
      && !(lookup_is_store_in && !lookup_rdata[PID_W + TAG_W + ACC_WRITE_BIT])
      && !(lookup_is_fetch_in && !lookup_rdata[PID_W + TAG_W + ACC_EXEC_BIT]);
    lookup_cacheable_out = lookup_hit_out && lookup_rdata[PID_W + TAG_W + ACC_CACHE_BIT];
    lookup_pfn_out = lookup_rdata[PID_W + TAG_W +: ACC_PFN_W];
  end

  always_comb
  begin
    misc_view = 32'h0000_0000;
    misc_view[MISC_DATA_BIT] = data_access_flag_q;
    misc_view[MISC_ACCESS_VIOLATION_FLAG_BIT] = access_violation_flag_q;
    misc_view[MISC_BAD_BIT] = bad_addr_flag_q;
    misc_view[MISC_DBL_BIT] = double_miss_flag_q;
    misc_view[MISC_PID_LSB +: PID_W] = process_identifier_q;
    misc_view[MISC_WE_BIT] = write_enable_q;
    misc_view[MISC_SET_LSB +: SET_W] = set_select_q;
    misc_view[MISC_EE_BIT] = soft_ecc_error_flag_q;
  end

  // registered read data; absent mmu reads zero
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ctl_rdata_out <= REG_RESET;
    else if (clk_en_in && ctl_rd_in)
    begin
      if (!MMU_PRESENT)
        ctl_rdata_out <= REG_RESET;
      else if (ctl_sel_in == SEL_PAGE_TABLE_POINTER)
        ctl_rdata_out <= {page_table_base_q, virtual_page_number_q, 2'b00};
      else if (ctl_sel_in == SEL_TLB_ENTRY_ACCESS)
        ctl_rdata_out <= {7'h00, entry_access_q};
      else if (ctl_sel_in == SEL_TLB_MISC_CONTROL)
        ctl_rdata_out <= misc_view;
      else
        ctl_rdata_out <= REG_RESET;
    end
  end
endmodule // tlb_access_control

/* tlb_access_control_assertions.sv */
`timescale 1ns/1ps
module tlb_access_control_assertions
  import tlb_ctrl_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic ctl_wr_in,
  input wire logic ctl_rd_in,
  input wire logic [1:0] ctl_sel_in,
  input wire logic [31:0] ctl_wdata_in,
  input wire logic [31:0] ctl_rdata_out,
  input wire logic ctl_busy_out,
  input wire logic exc_take_in,
  input wire logic exc_double_miss_in,
  input wire logic exc_access_violation_flag_in,
  input wire logic exc_data_in
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  logic quiet;
  logic rd_misc;
  logic trig;
  assign quiet = !exc_take_in && !ctl_wr_in;
  assign rd_misc = clk_en_in && ctl_rd_in && quiet && ctl_sel_in == SEL_TLB_MISC_CONTROL;
  assign trig = clk_en_in && ctl_wr_in && ctl_sel_in == SEL_TLB_MISC_CONTROL
    && ctl_wdata_in[MISC_RD_BIT];
  // fixed gap keeps a later exception from muddying the flags being read
  sequence s_exc_rd;
    clk_en_in && exc_take_in ##1 clk_en_in && quiet ##1 rd_misc;
  endsequence
  property p_busy; trig |=> ctl_busy_out; endproperty
  a_busy: assert property (p_busy) else $error("no busy after read trigger");
  property p_busy_one; clk_en_in && ctl_busy_out && !trig |=> !ctl_busy_out; endproperty
  a_busy_one: assert property (p_busy_one) else $error("busy too long");
  property p_hold; !(clk_en_in && ctl_rd_in) |=> $stable(ctl_rdata_out); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_rd_zero;
    clk_en_in && ctl_rd_in && ctl_sel_in == SEL_TLB_MISC_CONTROL |=> !ctl_rdata_out[MISC_RD_BIT];
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read trigger bit reads one");
  property p_os_zero;
    clk_en_in && ctl_rd_in && ctl_sel_in == SEL_TLB_ENTRY_ACCESS
      |=> ctl_rdata_out[31:ACC_STORED_W] == '0;
  endproperty
  a_os_zero: assert property (p_os_zero) else $error("os bits read nonzero");
  property p_two; s_exc_rd |=> ctl_rdata_out[MISC_DBL_BIT] == $past(exc_double_miss_in, 3);
  endproperty
  a_two: assert property (p_two) else $error("double miss flag wrong");
  property p_viol; s_exc_rd |=> ctl_rdata_out[MISC_ACCESS_VIOLATION_FLAG_BIT] == $past(exc_access_violation_flag_in, 3);
  endproperty
  a_viol: assert property (p_viol) else $error("violation flag wrong");
  property p_dacc; s_exc_rd |=> ctl_rdata_out[MISC_DATA_BIT] == $past(exc_data_in, 3);
  endproperty
  a_dacc: assert property (p_dacc) else $error("data access flag wrong");
  property p_we; s_exc_rd |=> !$past(exc_access_violation_flag_in, 3) || ctl_rdata_out[MISC_WE_BIT]; endproperty
  a_we: assert property (p_we) else $error("write enable not set");
  c_trig: cover property (trig);
  c_exc_rd: cover property (s_exc_rd);
  c_busy: cover property (ctl_busy_out);
endmodule // tlb_access_control_assertions

bind tlb_access_control tlb_access_control_assertions chk (.*);

/* cpu_pipe_model.sv */
`timescale 1ns/1ps
module cpu_pipe_model
  import tlb_ctrl_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic busy_in,
  input wire logic [31:0] rdata_in,
  output logic wr_out = 1'b0,
  output logic rd_out = 1'b0,
  output logic [1:0] sel_out = 2'h0,
  output logic [31:0] wdata_out = 32'h0
);
  task automatic wr(input logic [1:0] s, input logic [31:0] d);
    @(negedge sys_clk_in);
    sel_out = s;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge sys_clk_in);
    wr_out = 1'b0;
    // released data must not look valid
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [1:0] s, output logic [31:0] d);
    @(negedge sys_clk_in);
    while (busy_in !== 1'b0) @(negedge sys_clk_in);
    sel_out = s;
    rd_out = 1'b1;
    @(negedge sys_clk_in);
    rd_out = 1'b0;
    d = rdata_in;
  endtask
endmodule // cpu_pipe_model

/* tlb_access_control_test.sv */
`timescale 1ns/1ps
module tlb_access_control_test;
  import tlb_ctrl_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ctl_wr, ctl_rd, busy, hit, allowed, cacheable;
  logic [1:0] sel;
  logic [31:0] wdata, rdata;
  logic exc_take = 1'b0, hnd = 1'b0, fmiss = 1'b0, dmiss = 1'b0, viol = 1'b0, dacc = 1'b0;
  logic [19:0] fault_page = 20'h0, look_page = 20'h0, frame;
  logic ld = 1'b0, st = 1'b0;
  logic cke = 1'b1, bad = 1'b0, ecc_en = 1'b0, ecc_err = 1'b0, fe = 1'b0;
  logic [31:0] acc_tab [4] = '{32'hFF90_0001, 32'hFE20_0002, 32'hFE40_0003, 32'hFE00_0004};
  int fail_count = 0, checks_done = 0, cyc = 0;
  tlb_access_control #(.PID_W(8), .NUM_SETS(4), .LINE_W(4), .MMU_PRESENT(1'b1)) DUT (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .clk_en_in(cke), .ctl_wr_in(ctl_wr),
    .ctl_rd_in(ctl_rd), .ctl_sel_in(sel), .ctl_wdata_in(wdata), .ctl_rdata_out(rdata),
    .ctl_busy_out(busy), .exc_take_in(exc_take), .exc_handling_bit_in(hnd),
    .exc_fast_miss_in(fmiss), .exc_double_miss_in(dmiss), .exc_access_violation_flag_in(viol),
    .exc_bad_addr_in(bad), .exc_data_in(dacc), .exc_vpn_in(fault_page), .ecc_enable_in(ecc_en),
    .ecc_error_in(ecc_err), .lookup_vpn_in(look_page), .lookup_is_load_in(ld),
    .lookup_is_store_in(st), .lookup_is_fetch_in(fe), .lookup_hit_out(hit),
    .lookup_allowed_out(allowed), .lookup_cacheable_out(cacheable), .lookup_pfn_out(frame));
  cpu_pipe_model cpu (.sys_clk_in(sys_clk_in), .busy_in(busy), .rdata_in(rdata),
    .wr_out(ctl_wr), .rd_out(ctl_rd), .sel_out(sel), .wdata_out(wdata));
  initial
  begin
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rc(input logic [1:0] s, input string n, input logic [31:0] e);
    logic [31:0] r;
    cpu.rd(s, r);
    chk(n, r, e);
  endtask
  // k is {load, store, fetch}; outputs are combinational, judged a cycle later
  task automatic lk(input logic [19:0] p, input logic [2:0] k, input string n,
      input logic [31:0] e);
    @(negedge sys_clk_in);
    look_page = p;
    {ld, st, fe} = k;
    @(negedge sys_clk_in);
    chk(n, {9'h0, hit, allowed, cacheable, frame}, e);
    {ld, st, fe} = 3'b000;
  endtask
  // q is {handling, fast miss, double miss, violation, data access, bad address}
  task automatic exc(input logic [19:0] v, input logic [5:0] q);
    @(negedge sys_clk_in);
    {hnd, fmiss, dmiss, viol, dacc, bad} = q;
    fault_page = v;
    exc_take = 1'b1;
    @(negedge sys_clk_in);
    exc_take = 1'b0;
  endtask
  task automatic t_reset();
    rc(SEL_PAGE_TABLE_POINTER, "ptp", REG_RESET);
    rc(SEL_TLB_ENTRY_ACCESS, "acc", REG_RESET);
    rc(SEL_TLB_MISC_CONTROL, "misc", REG_RESET);
  endtask
  task automatic t_tlb();
    int i;
    logic [31:0] e;
    cpu.wr(SEL_TLB_MISC_CONTROL, 32'h0004_05A0);
    for (i = 0; i < 4; i++)
    begin
      cpu.wr(SEL_PAGE_TABLE_POINTER, (32'h0001_2303 + 32'(i * 16)) << PTP_VPN_LSB);
      cpu.wr(SEL_TLB_ENTRY_ACCESS, acc_tab[i]);
      e = 32'h0004_05A0 | (32'((i + 1) % 4) << MISC_SET_LSB);
      rc(SEL_TLB_MISC_CONTROL, "set step", e);
    end
    // selection changes alone must not disturb the loaded registers
    cpu.wr(SEL_TLB_MISC_CONTROL, 32'h0020_0330);
    cpu.wr(SEL_PAGE_TABLE_POINTER, 32'h001D_DDCC);
    cpu.wr(SEL_TLB_ENTRY_ACCESS, 32'h0000_0ABC);
    rc(SEL_TLB_ENTRY_ACCESS, "acc sw", 32'h0000_0ABC);
    rc(SEL_PAGE_TABLE_POINTER, "page kept", 32'h001D_DDCC);
    cpu.wr(SEL_TLB_MISC_CONTROL, 32'h0028_0330);
    rc(SEL_TLB_ENTRY_ACCESS, "acc entry", acc_tab[2] & 32'h01FF_FFFF);
    rc(SEL_PAGE_TABLE_POINTER, "page entry", 32'h0004_8C8C);
    rc(SEL_TLB_MISC_CONTROL, "misc entry", 32'h0020_05A0);
  endtask
  task automatic t_look();
    lk(20'h12303, 3'b100, "load", 32'h0070_0001);
    lk(20'h12303, 3'b010, "store", 32'h0050_0001);
    // private entry in set 0, line 5, owned by process 0x77
    cpu.wr(SEL_TLB_MISC_CONTROL, 32'h0004_0770);
    cpu.wr(SEL_PAGE_TABLE_POINTER, 32'h0004_8C94);
    cpu.wr(SEL_TLB_ENTRY_ACCESS, 32'h0060_0009);
    lk(20'h12325, 3'b001, "fetch", 32'h0060_0009);
    lk(20'h12325, 3'b100, "no load", 32'h0040_0009);
    cpu.wr(SEL_TLB_MISC_CONTROL, 32'h0000_0110);
    lk(20'h12325, 3'b001, "pid miss", 32'h0000_0009);
  endtask
  task automatic t_exc();
    cpu.wr(SEL_TLB_MISC_CONTROL, 32'h0);
    cpu.wr(SEL_PAGE_TABLE_POINTER, 32'hFFC0_0000);
    exc(20'h0A5A5, 6'b010010);
    rc(SEL_TLB_MISC_CONTROL, "misc miss", 32'h0004_0001);
    rc(SEL_PAGE_TABLE_POINTER, "ptp miss", 32'hFFC2_9694);
    cpu.wr(SEL_TLB_MISC_CONTROL, 32'h0);
    exc(20'h11111, 6'b101000);
    rc(SEL_TLB_MISC_CONTROL, "misc two", 32'h0000_0008);
    exc(20'h22222, 6'b100111);
    rc(SEL_TLB_MISC_CONTROL, "misc viol", 32'h0004_0007);
    rc(SEL_PAGE_TABLE_POINTER, "ptp held", 32'hFFC2_9694);
  endtask
  task automatic t_ecc();
    @(negedge sys_clk_in);
    ecc_en = 1'b1;
    ecc_err = 1'b1;
    cpu.wr(SEL_TLB_MISC_CONTROL, 32'h0008_0000);
    rc(SEL_TLB_MISC_CONTROL, "misc ecc", 32'h0100_0777);
    rc(SEL_PAGE_TABLE_POINTER, "ptp ecc", 32'hFFC4_8C94);
    rc(SEL_TLB_ENTRY_ACCESS, "acc ecc", 32'h0060_0009);
    @(negedge sys_clk_in);
    ecc_en = 1'b0;
    ecc_err = 1'b0;
    cpu.wr(SEL_TLB_MISC_CONTROL, 32'h0100_0000);
    rc(SEL_TLB_MISC_CONTROL, "ee blocked", 32'h0000_0007);
  endtask
  task automatic t_freeze();
    @(negedge sys_clk_in);
    cke = 1'b0;
    cpu.wr(SEL_PAGE_TABLE_POINTER, 32'h0000_0400);
    cke = 1'b1;
    rc(SEL_PAGE_TABLE_POINTER, "frozen", 32'hFFC4_8C94);
  endtask
  task automatic t_rerun();
    @(negedge sys_clk_in);
    rst_n_in = 1'b0;
    @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    t_reset();
  endtask
  initial
  begin
    repeat (10) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    t_reset();
    t_tlb();
    t_look();
    t_exc();
    t_ecc();
    t_freeze();
    t_rerun();
    give_verdict();
  end
endmodule // tlb_access_control_test
